//--- ist_core.sv
// i2c slave timing core: clock enable divider, status flags, stall, sleep wake and handover
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "ist_params.svh"

// ==========================================================
// core module
// Overview of operation
// - runs from 6-24 MHz core clock, SCL up to 400 KHz
// - 4-bit divider makes the divided clock enable
// - sixteen or thirty-two samples per SCL bit
// - rate 00/10: divide by 8, 4, 16
// - rate 01: 2, 1, 4; rate 11: 1
// - byte complete at eighth rising SCL edge
// - flags set clock after synchronised SCL rise
// - address flag only after an address byte
// - last ack bit captured on ninth bit
// - stop flag three enables after stop condition
// - no control write by fall: hold SCL low
// - control write releases the stalled SCL
// - output data set up N-1 clocks before rise
// - SDA edges drive start/stop detection in sleep
// - respond in sleep only with power down high
// - address match alone wakes the system
// - compatibility mode holds SCL until firmware answers
// - address match raises wake and handover request
// - wake request goes to the sleep controller
// - registered handover clears the raw handover request
// - handover keeps the transfer state consistent
// - control write before fall: no stall at all
module ist_core (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire ist_pkg::ist_apb_req_type apb_req,
  output ist_pkg::ist_apb_rsp_type apb_rsp,
  input wire logic scl_in,
  input wire logic sda_in,
  output ist_pkg::ist_pins_type pins,
  input wire logic power_down_signal,
  output logic irq,
  output logic wake_irq,
  output logic sampled_clock_handover
);

  ist_pkg::ist_state_type s_ff;
  ist_pkg::ist_state_type nxt_s;
  logic tick;
  logic scl_new;
  logic sda_new;
  logic rise;
  logic fall;
  logic start_ev;
  logic stop_ev;
  logic access;
  logic wr;
  logic wr_scr;
  logic mapped;
  logic addr_eq;
  logic accept;

  // ==========================================================
  // helper functions
  // divide factor from rate code and oscillator speed select
  function automatic logic [4:0] div_factor(input logic [1:0] rate, input logic [1:0] osc);
    logic [4:0] f;
    f = `IST_DIV_TURBO;
    if (rate == 2'h3) begin
      f = `IST_DIV_TURBO;
    end else if (rate == 2'h1) begin
      f = (osc == 2'h0) ? `IST_DIV_FAST_12 : (osc == 2'h1) ? `IST_DIV_FAST_6 : `IST_DIV_FAST_24;
    end else begin
      f = (osc == 2'h0) ? `IST_DIV_STD_12 : (osc == 2'h1) ? `IST_DIV_STD_6 : `IST_DIV_STD_24;
    end
    return f;
  endfunction

  // samples per bit: only the slow rate uses the doubled count
  function automatic logic [5:0] samples_per_bit(input logic [1:0] rate);
    return (rate == 2'h2) ? `IST_SPB_32 : `IST_SPB_16;
  endfunction

  // ==========================================================
  // combinational decode
  // divided clock enable: one cycle in every factor cycles
  // compare with at-or-above so a smaller factor takes effect at once instead of wrapping through 15
  assign tick = ({1'b0, s_ff.div_cnt} >= div_factor(s_ff.rate, s_ff.osc) - 5'h01);
  // filter takes a new level only when two enable samples agree
  assign scl_new = (tick && s_ff.scl_s2 == s_ff.scl_p) ? s_ff.scl_s2 : s_ff.scl_f;
  assign sda_new = (tick && s_ff.sda_s2 == s_ff.sda_p) ? s_ff.sda_s2 : s_ff.sda_f;
  assign rise = !s_ff.scl_f && scl_new;
  assign fall = s_ff.scl_f && !scl_new;
  // start and stop are data edges while the clock stays high
  assign start_ev = s_ff.scl_f && scl_new && s_ff.sda_f && !sda_new;
  assign stop_ev = s_ff.scl_f && scl_new && !s_ff.sda_f && sda_new;
  assign access = apb_req.psel && apb_req.penable;
  assign wr = access && apb_req.pwrite;
  assign wr_scr = wr && apb_req.paddr == `IST_OFF_SCR;
  assign mapped = apb_req.paddr == `IST_OFF_CFG || apb_req.paddr == `IST_OFF_SCR ||
                  apb_req.paddr == `IST_OFF_DATA || apb_req.paddr == `IST_OFF_XSTAT;
  // first seven bits of the address byte sit in shift[6:0]
  assign addr_eq = s_ff.shift[6:0] == s_ff.own_addr;
  // asleep in reject mode with stretch clear the address is refused even on a match
  assign accept = (!s_ff.hw_en || addr_eq) &&
                  !(power_down_signal && s_ff.rej_req && !s_ff.stretch);

  // ==========================================================
  // next state
  always_comb begin
    nxt_s = s_ff;
    // two-flop synchronisers; first stage feeds only the second
    nxt_s.scl_s1 = scl_in;
    nxt_s.scl_s2 = s_ff.scl_s1;
    nxt_s.sda_s1 = sda_in;
    nxt_s.sda_s2 = s_ff.sda_s1;
    nxt_s.div_cnt = tick ? 4'h0 : s_ff.div_cnt + 4'h1;
    if (tick) begin
      nxt_s.scl_p = s_ff.scl_s2;
      nxt_s.sda_p = s_ff.sda_s2;
    end
    nxt_s.scl_f = scl_new;
    nxt_s.sda_f = sda_new;
    // read data is captured in the setup cycle so it leaves a flop
    if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      nxt_s.prdata = 32'h00000000;
      if (apb_req.paddr == `IST_OFF_CFG) begin
        nxt_s.prdata[`IST_CFG_RATE] = s_ff.rate;
        nxt_s.prdata[`IST_CFG_OSC] = s_ff.osc;
        nxt_s.prdata[`IST_CFG_HWEN] = s_ff.hw_en;
        nxt_s.prdata[`IST_CFG_REJ] = s_ff.rej_req;
        nxt_s.prdata[`IST_CFG_STRETCH] = s_ff.stretch;
        nxt_s.prdata[`IST_CFG_ADDR] = s_ff.own_addr;
      end else if (apb_req.paddr == `IST_OFF_SCR) begin
        nxt_s.prdata[`IST_SCR_BC] = s_ff.bc;
        nxt_s.prdata[`IST_SCR_LRB] = s_ff.last_received_ack_bit;
        nxt_s.prdata[`IST_SCR_TX] = s_ff.tx;
        nxt_s.prdata[`IST_SCR_ADDR] = s_ff.addr_flag;
        nxt_s.prdata[`IST_SCR_ACK] = s_ff.ack;
        nxt_s.prdata[`IST_SCR_STOP] = s_ff.stop_flag;
      end else if (apb_req.paddr == `IST_OFF_DATA) begin
        nxt_s.prdata[7:0] = s_ff.data;
      end else if (apb_req.paddr == `IST_OFF_XSTAT) begin
        nxt_s.prdata[`IST_XS_READY] = s_ff.rej_req && s_ff.phase == ist_pkg::IST_IDLE;
        nxt_s.prdata[`IST_XS_HANDOVER] = s_ff.handover_reg;
        nxt_s.prdata[`IST_XS_WAKE] = s_ff.wake_set;
        nxt_s.prdata[`IST_XS_SPB] = samples_per_bit(s_ff.rate);
      end
    end
    // software writes; hardware events below override, so a set wins
    if (wr && apb_req.paddr == `IST_OFF_CFG) begin
      nxt_s.rate = apb_req.pwdata[`IST_CFG_RATE];
      nxt_s.osc = apb_req.pwdata[`IST_CFG_OSC];
      nxt_s.hw_en = apb_req.pwdata[`IST_CFG_HWEN];
      nxt_s.rej_req = apb_req.pwdata[`IST_CFG_REJ];
      nxt_s.stretch = apb_req.pwdata[`IST_CFG_STRETCH];
      nxt_s.own_addr = apb_req.pwdata[`IST_CFG_ADDR];
    end else if (wr_scr) begin
      nxt_s.tx = apb_req.pwdata[`IST_SCR_TX];
      nxt_s.ack = apb_req.pwdata[`IST_SCR_ACK];
      nxt_s.bc = s_ff.bc && apb_req.pwdata[`IST_SCR_BC];
      nxt_s.last_received_ack_bit = s_ff.last_received_ack_bit && apb_req.pwdata[`IST_SCR_LRB];
      nxt_s.addr_flag = s_ff.addr_flag && apb_req.pwdata[`IST_SCR_ADDR];
      nxt_s.stop_flag = s_ff.stop_flag && apb_req.pwdata[`IST_SCR_STOP];
      // this write continues the transfer and ends any stall
      nxt_s.pend = 1'b0;
      nxt_s.stall = 1'b0;
      if (apb_req.pwdata[`IST_SCR_TX]) begin
        nxt_s.shift = s_ff.data;
      end
      // stalled in our ack slot: the ack answer goes out as scl is freed
      if (s_ff.stall && s_ff.bit_cnt == 4'h8 && !s_ff.cur_tx) begin
        nxt_s.sda_drv = apb_req.pwdata[`IST_SCR_ACK];
      end
    end else if (wr && apb_req.paddr == `IST_OFF_DATA) begin
      nxt_s.data = apb_req.pwdata[7:0];
    end
    // stop flag waits a fixed count of divided enables
    if (tick && s_ff.stop_arm) begin
      nxt_s.stop_cnt = s_ff.stop_cnt + 2'h1;
      if (s_ff.stop_cnt == `IST_STOP_TICKS - 2'h1) begin
        nxt_s.stop_flag = 1'b1;
        nxt_s.stop_arm = 1'b0;
      end
    end
    // bus events, seen only through the filtered lines
    if (start_ev) begin
      nxt_s.phase = ist_pkg::IST_ADDR;
      nxt_s.bit_cnt = 4'h0;
      nxt_s.cur_tx = 1'b0;
      nxt_s.tx = 1'b0;
      nxt_s.bc = 1'b0;
      nxt_s.last_received_ack_bit = 1'b0;
      nxt_s.sda_drv = 1'b0;
      nxt_s.stop_arm = 1'b0;
      nxt_s.pend = 1'b0;
      nxt_s.stall = 1'b0;
    end else if (stop_ev) begin
      nxt_s.phase = ist_pkg::IST_IDLE;
      nxt_s.stop_arm = 1'b1;
      nxt_s.stop_cnt = 2'h0;
      nxt_s.sda_drv = 1'b0;
    end else if (rise && s_ff.phase != ist_pkg::IST_IDLE) begin
      nxt_s.bit_cnt = s_ff.bit_cnt + 4'h1;
      if (s_ff.bit_cnt < 4'h8) begin
        nxt_s.shift = {s_ff.shift[6:0], s_ff.cur_tx ? 1'b0 : sda_new};
      end
      if (s_ff.bit_cnt == 4'h7) begin
        if (!s_ff.cur_tx) begin
          nxt_s.data = {s_ff.shift[6:0], sda_new};
        end
        // wake only on our own address while powered down
        if (s_ff.phase == ist_pkg::IST_ADDR && power_down_signal && s_ff.hw_en && addr_eq) begin
          nxt_s.wake_set = 1'b1;
        end
        if (s_ff.phase == ist_pkg::IST_ADDR && !accept) begin
          nxt_s.phase = ist_pkg::IST_IDLE; // not ours: stay silent
        end else begin
          nxt_s.bc = 1'b1;
          nxt_s.pend = !wr_scr;
          if (s_ff.phase == ist_pkg::IST_ADDR) begin
            nxt_s.addr_flag = 1'b1;
          end
        end
      end
      if (s_ff.bit_cnt == 4'h8 && s_ff.cur_tx) begin
        nxt_s.last_received_ack_bit = sda_new;
      end
    end else if (fall && s_ff.phase != ist_pkg::IST_IDLE) begin
      // firmware that has not answered by now stalls the bus
      nxt_s.stall = s_ff.pend && !wr_scr;
      if (s_ff.bit_cnt == 4'h8) begin
        nxt_s.sda_drv = !s_ff.cur_tx && s_ff.ack;
      end else if (s_ff.bit_cnt == 4'h9) begin
        nxt_s.bit_cnt = 4'h0;
        nxt_s.cur_tx = s_ff.tx;
        nxt_s.phase = ist_pkg::IST_DATA;
        nxt_s.sda_drv = s_ff.tx && !s_ff.shift[7];
        // master nack on transmit, or firmware nack on receive, ends it
        if ((s_ff.cur_tx && s_ff.last_received_ack_bit) || (!s_ff.cur_tx && !s_ff.ack)) begin
          nxt_s.phase = ist_pkg::IST_IDLE;
          nxt_s.sda_drv = 1'b0;
        end
      end else begin
        nxt_s.sda_drv = s_ff.cur_tx && !s_ff.shift[7];
      end
    end
    // handover: register once the oscillator runs, then retire both
    if (s_ff.handover_reg) begin
      nxt_s.handover_reg = 1'b0;
      nxt_s.wake_set = 1'b0;
    end else if (s_ff.wake_set && !power_down_signal) begin
      nxt_s.handover_reg = 1'b1;
    end
  end

  // ==========================================================
  // state register; async reset loads constants only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= ist_pkg::ist_state_type'({$bits(ist_pkg::ist_state_type){`IST_RST_ALL}});
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================
  // outputs
  // zero-wait slave: the answer comes in the access cycle
  assign apb_rsp.prdata = s_ff.prdata;
  assign apb_rsp.pready = access;
  assign apb_rsp.pslverr = access && !mapped;
  // open-drain pins only ever pull low
  assign pins.scl_o = 1'b0;
  assign pins.scl_oe = s_ff.stall;
  assign pins.sda_o = 1'b0;
  assign pins.sda_oe = s_ff.sda_drv;
  assign irq = s_ff.bc || s_ff.stop_flag;
  assign wake_irq = s_ff.wake_set;
  // raw handover falls as soon as its registered copy rises
  assign sampled_clock_handover = s_ff.wake_set && !s_ff.handover_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_stalled;
    pins.scl_oe && !wr_scr;
  endsequence
  sequence s_released;
    wr_scr ##1 !pins.scl_oe;
  endsequence

  property p_div_wrap;
    tick |=> s_ff.div_cnt == 4'h0 ##1 s_ff.div_cnt == 4'h1 || tick;
  endproperty
  a_div_wrap: assert property (p_div_wrap) else $error("divider did not wrap");

  property p_fast_factor;
    tick && s_ff.rate == 2'h1 && s_ff.osc == 2'h0 ##1 $stable({s_ff.rate, s_ff.osc}) [*2] |-> tick && !$past(tick);
  endproperty
  a_fast_factor: assert property (p_fast_factor) else $error("wrong fast divide factor");

  property p_std_factor;
    s_ff.rate == 2'h2 && s_ff.osc == 2'h2 |-> tick == (s_ff.div_cnt == 4'hF);
  endproperty
  a_std_factor: assert property (p_std_factor) else $error("wrong slow divide factor");

  property p_byte_done;
    rise && s_ff.phase == ist_pkg::IST_DATA && s_ff.bit_cnt == 4'h7 && !start_ev |=> s_ff.bc && irq;
  endproperty
  a_byte_done: assert property (p_byte_done) else $error("byte complete missed");

  property p_addr_flag;
    $rose(s_ff.addr_flag) |-> $past(s_ff.phase) == ist_pkg::IST_ADDR && s_ff.bc;
  endproperty
  a_addr_flag: assert property (p_addr_flag) else $error("address flag outside address byte");

  property p_lrb;
    rise && s_ff.cur_tx && s_ff.bit_cnt == 4'h8 && !start_ev && !stop_ev |=> s_ff.last_received_ack_bit == $past(sda_new);
  endproperty
  a_lrb: assert property (p_lrb) else $error("ack bit not captured");

  property p_stop;
    $rose(s_ff.stop_flag) |-> $past(s_ff.stop_cnt) == 2'h2;
  endproperty
  a_stop: assert property (p_stop) else $error("stop flag early");

  property p_stall;
    fall && s_ff.phase != ist_pkg::IST_IDLE && s_ff.pend && !wr_scr && !start_ev && !stop_ev
      |=> pins.scl_oe;
  endproperty
  a_stall: assert property (p_stall) else $error("no stall after late answer");

  property p_release;
    s_stalled ##1 wr_scr |-> s_released;
  endproperty
  a_release: assert property (p_release) else $error("stall not released");

  property p_sync;
    rst_n ##2 1'b1 |-> s_ff.scl_s2 == $past(scl_in, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("scl synchroniser depth wrong");

  property p_handover;
    s_ff.handover_reg |-> !sampled_clock_handover ##1 !s_ff.wake_set;
  endproperty
  a_handover: assert property (p_handover) else $error("handover request not retired");

endmodule

//--- ist_core_tb.sv
// self-checking testbench of the i2c slave timing core
`timescale 1ns/1ps
`include "ist_params.svh"
// ==========================================================
// bench top
module ist_core_tb;
  logic sys_clk;
  logic rst_n;
  logic power_down_signal;
  ist_pkg::ist_apb_req_type apb_req;
  ist_pkg::ist_apb_rsp_type apb_rsp;
  ist_pkg::ist_pins_type pins;
  logic irq, wake_irq, sampled_clock_handover;
  logic scl_pull, sda_pull, stuck, stall_seen;
  logic scl_line, sda_line;
  int miscompares, comparisons;
  logic [31:0] rd, cfg;
  logic err, s9;
  logic [6:0] own;
  logic [7:0] rx, d;
  logic [7:0] exp_q[$];
  // open-drain lines with pull-ups
  assign scl_line = ~(scl_pull | pins.scl_oe);
  assign sda_line = ~(sda_pull | pins.sda_oe);
  ist_core DUT (.sys_clk(sys_clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .scl_in(scl_line),
    .sda_in(sda_line), .pins(pins), .power_down_signal(power_down_signal), .irq(irq), .wake_irq(wake_irq),
    .sampled_clock_handover(sampled_clock_handover));
  ist_i2c_master #(.HALF(40)) u_mst (.sys_clk(sys_clk), .scl_line(scl_line), .sda_line(sda_line),
    .scl_pull(scl_pull), .sda_pull(sda_pull), .stuck(stuck));
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (pins.scl_oe === 1'b1) stall_seen <= 1'b1;
  // ==========================================================
  // report and compare helpers
  task automatic test_done();
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bad(input string m);
    miscompares++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) bad(m);
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    apb_req.psel <= 1'b1;
    apb_req.pwrite <= wr;
    apb_req.paddr <= a;
    apb_req.pwdata <= wd;
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad("apb hang");
      test_done();
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  // poll the control/status register until byte complete, bounded
  task automatic wait_bc();
    int n;
    n = 0;
    do begin
      apb(1'b0, `IST_OFF_SCR, 32'h0);
      n++;
    end while (rd[`IST_SCR_BC] !== 1'b1 && n < 400);
    if (n >= 400) begin
      bad("no byte complete");
      test_done();
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    power_down_signal = 1'b0;
    apb_req = '0;
    stall_seen = 1'b0;
    miscompares = 0;
    comparisons = 0;
    void'($urandom(30));
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    apb(1'b0, `IST_OFF_SCR, 32'h0);
    chk(rd, 32'h0, "scr reset");
    // samples per bit for every rate code
    for (int r = 0; r < 4; r++) begin
      // the slow rate also runs with the fastest oscillator setting
      apb(1'b1, `IST_OFF_CFG, (r == 2) ? 32'h0000000A : 32'(r));
      apb(1'b0, `IST_OFF_XSTAT, 32'h0);
      chk({26'h0, rd[`IST_XS_SPB]}, (r == 2) ? 32'h20 : 32'h10, "samples per bit");
    end
    apb(1'b1, 12'h010, $urandom);
    chk({31'h0, err}, 32'h1, "unmapped write err");
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0, "unmapped read data");
    own = 7'($urandom_range(8, 119));
    cfg = {17'h0, own, 8'h07};
    apb(1'b1, `IST_OFF_CFG, cfg);
    // address byte left unanswered: bus must stall until the control write
    fork
      begin
        u_mst.start_cond();
        u_mst.xfer_byte({own, 1'b0}, 1'b1, rx, s9);
        chk({31'h0, s9}, 32'h0, "address ack");
      end
      begin
        wait_bc();
        chk({31'h0, rd[`IST_SCR_ADDR]}, 32'h1, "address flag");
        chk({31'h0, irq}, 32'h1, "irq on byte complete");
        repeat (300) @(posedge sys_clk);
        chk({31'h0, pins.scl_oe}, 32'h1, "scl held low");
        apb(1'b1, `IST_OFF_SCR, 32'h10);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, pins.scl_oe}, 32'h0, "stall released");
      end
    join
    // data byte answered at once: no stall at all
    d = 8'($urandom);
    exp_q.push_back(d);
    stall_seen = 1'b0;
    fork
      u_mst.xfer_byte(d, 1'b1, rx, s9);
      begin
        wait_bc();
        apb(1'b0, `IST_OFF_DATA, 32'h0);
        apb(1'b1, `IST_OFF_SCR, 32'h10);
      end
    join
    chk(rd[7:0], exp_q.pop_front(), "received byte");
    chk({31'h0, stall_seen}, 32'h0, "no stall when answered early");
    u_mst.stop_cond();
    repeat (20) @(posedge sys_clk);
    apb(1'b0, `IST_OFF_SCR, 32'h0);
    chk({31'h0, rd[`IST_SCR_STOP]}, 32'h1, "stop flag");
    apb(1'b1, `IST_OFF_SCR, 32'h0);
    // master read ended by nack: last ack bit captured
    d = 8'($urandom);
    fork
      begin
        u_mst.start_cond();
        u_mst.xfer_byte({own, 1'b1}, 1'b1, rx, s9);
        u_mst.xfer_byte(8'hFF, 1'b1, rx, s9);
        chk(rx, d, "transmitted byte");
        u_mst.stop_cond();
      end
      begin
        wait_bc();
        apb(1'b1, `IST_OFF_DATA, d);
        apb(1'b1, `IST_OFF_SCR, 32'h14);
        wait_bc();
        apb(1'b1, `IST_OFF_SCR, 32'h0);
      end
    join
    apb(1'b0, `IST_OFF_SCR, 32'h0);
    chk({31'h0, rd[`IST_SCR_LRB]}, 32'h1, "last ack bit");
    apb(1'b1, `IST_OFF_SCR, 32'h0);
    // asleep: only a matching address wakes and hands over to sampled clocking
    apb(1'b1, `IST_OFF_CFG, cfg | 32'h10);
    power_down_signal <= 1'b1;
    u_mst.start_cond();
    u_mst.xfer_byte({own ^ 7'h01, 1'b0}, 1'b1, rx, s9);
    u_mst.stop_cond();
    chk({31'h0, wake_irq}, 32'h0, "no wake on mismatch");
    fork
      begin
        u_mst.start_cond();
        u_mst.xfer_byte({own, 1'b0}, 1'b1, rx, s9);
        u_mst.stop_cond();
      end
      begin
        for (int n = 0; n < 2000 && wake_irq !== 1'b1; n++) @(posedge sys_clk);
        chk({31'h0, wake_irq}, 32'h1, "wake on match");
        chk({31'h0, sampled_clock_handover}, 32'h1, "handover request");
        power_down_signal <= 1'b0;
        for (int n = 0; n < 20 && sampled_clock_handover !== 1'b0; n++) @(posedge sys_clk);
        chk({31'h0, sampled_clock_handover}, 32'h0, "handover request cleared");
        apb(1'b1, `IST_OFF_SCR, 32'h10);
      end
    join
    // reject mode: firmware asks for reject and polls ready before powering down
    apb(1'b1, `IST_OFF_CFG, cfg | 32'h30);
    rd = 32'h0;
    for (int n = 0; n < 20 && rd[`IST_XS_READY] !== 1'b1; n++) apb(1'b0, `IST_OFF_XSTAT, 32'h0);
    chk({31'h0, rd[`IST_XS_READY]}, 32'h1, "ready to reject");
    power_down_signal <= 1'b1;
    u_mst.start_cond();
    u_mst.xfer_byte({own, 1'b0}, 1'b1, rx, s9);
    chk({31'h0, s9}, 32'h1, "address refused while asleep");
    apb(1'b0, `IST_OFF_XSTAT, 32'h0);
    chk({31'h0, rd[`IST_XS_WAKE]}, 32'h1, "wake status while asleep");
    power_down_signal <= 1'b0;
    u_mst.stop_cond();
    chk({30'h0, pins.scl_o, pins.sda_o}, 32'h0, "open drain levels");
    chk({31'h0, stuck}, 32'h0, "bus never stuck");
    test_done();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    bad("timeout");
    test_done();
  end
endmodule

//--- ist_i2c_master.sv
// behavioural i2c bus master that faces the slave timing core
`timescale 1ns/1ps
// ==========================================================
// bus master model
module ist_i2c_master #(parameter int HALF = 40) (
  input wire logic sys_clk,
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_pull,
  output logic sda_pull,
  output logic stuck
);
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    stuck = 1'b0;
  end
  task automatic half_wait();
    repeat (HALF) @(posedge sys_clk);
  endtask
  // release scl and wait out any stretch by the slave before timing the high phase
  task automatic clk_high(output logic smp);
    int n;
    n = 0;
    scl_pull <= 1'b0;
    @(posedge sys_clk);
    while (scl_line !== 1'b1 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 4000) stuck <= 1'b1;
    smp = sda_line;
    half_wait();
  endtask
  // sda moves only well after scl fell, so no false start or stop is seen
  task automatic put_bit(input logic b, output logic smp);
    repeat (8) @(posedge sys_clk);
    sda_pull <= ~b;
    half_wait();
    clk_high(smp);
    scl_pull <= 1'b1;
  endtask
  task automatic start_cond();
    half_wait();
    sda_pull <= 1'b1;
    half_wait();
    scl_pull <= 1'b1;
  endtask
  task automatic stop_cond();
    logic d;
    repeat (8) @(posedge sys_clk);
    sda_pull <= 1'b1;
    half_wait();
    clk_high(d);
    sda_pull <= 1'b0;
    half_wait();
  endtask
  // eight bits msb first, then the ninth bit; a released line reads back the slave
  task automatic xfer_byte(input logic [7:0] tx, input logic n9, output logic [7:0] rx, output logic s9);
    for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
    put_bit(n9, s9);
  endtask
endmodule

//--- ist_params.svh
// register map, field positions, reset values and timing counts of the i2c slave timing core
`ifndef IST_PARAMS_SVH
`define IST_PARAMS_SVH
// register byte offsets
`define IST_OFF_CFG 12'h000
`define IST_OFF_SCR 12'h004
`define IST_OFF_DATA 12'h008
`define IST_OFF_XSTAT 12'h00C
// config register fields
`define IST_CFG_RATE 1:0
`define IST_CFG_OSC 3:2
`define IST_CFG_HWEN 4
`define IST_CFG_REJ 5
`define IST_CFG_STRETCH 6
`define IST_CFG_ADDR 14:8
// slave control/status fields
`define IST_SCR_BC 0
`define IST_SCR_LRB 1
`define IST_SCR_TX 2
`define IST_SCR_ADDR 3
`define IST_SCR_ACK 4
`define IST_SCR_STOP 5
// extended status fields
`define IST_XS_READY 0
`define IST_XS_HANDOVER 1
`define IST_XS_WAKE 2
`define IST_XS_SPB 13:8
// reset value of every register bit
`define IST_RST_ALL 1'b0
// divide factors: standard/slow rates, fast rate, turbo rate
`define IST_DIV_STD_12 5'h08
`define IST_DIV_STD_6 5'h04
`define IST_DIV_STD_24 5'h10
`define IST_DIV_FAST_12 5'h02
`define IST_DIV_FAST_6 5'h01
`define IST_DIV_FAST_24 5'h04
`define IST_DIV_TURBO 5'h01
// samples per scl bit
`define IST_SPB_16 6'h10
`define IST_SPB_32 6'h20
// divided enables from stop condition to stop flag
`define IST_STOP_TICKS 2'h3
`endif

//--- ist_pkg.sv
// types shared by the i2c slave timing core
package ist_pkg;
  typedef enum logic [1:0] {
    IST_IDLE = 2'b00,
    IST_ADDR = 2'b01,
    IST_DATA = 2'b10
  } ist_phase_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ist_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ist_apb_rsp_type;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } ist_pins_type;

  typedef struct packed {
    logic [3:0] div_cnt;
    logic scl_s1, scl_s2, sda_s1, sda_s2;
    logic scl_p, sda_p, scl_f, sda_f;
    ist_phase_type phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] data;
    logic cur_tx, tx, ack, bc, addr_flag, last_received_ack_bit, stop_flag;
    logic stop_arm;
    logic [1:0] stop_cnt;
    logic pend, stall, sda_drv;
    logic [1:0] rate, osc;
    logic hw_en, rej_req, stretch;
    logic [6:0] own_addr;
    logic wake_set, handover_reg;
    logic [31:0] prdata;
  } ist_state_type;
endpackage
